// File: pkg/evd_regs.svh
/*
  constants for the error vector dispatch block: control-block entry
  indices, error source bit positions and timing figures.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef EVD_REGS_SVH
`define EVD_REGS_SVH

// ============================================================
// control-block entry indices (byte offsets into the table)
`define EVD_IDX_MACHINE_CHECK 9'h004
`define EVD_IDX_KSTACK_INVALID 9'h008
`define EVD_IDX_POWER_FAIL 9'h00C
`define EVD_IDX_SOFT_ERROR 9'h054
`define EVD_IDX_HARD_ERROR 9'h060

// ============================================================
// timing
`define EVD_CLK_PERIOD_NS 25
`define EVD_POWER_FAIL_MS 20

// ============================================================
// error source bit positions in the classifier input vector
`define EVD_SRC_FP 0
`define EVD_SRC_MMGT 1
`define EVD_SRC_UCODE 2
`define EVD_SRC_PC_TAG_RD 3
`define EVD_SRC_PC_DATA_RD 4
`define EVD_SRC_PC_TAG_WR 5
`define EVD_SRC_BC_DATA_RD 6
`define EVD_SRC_BC_TAG_RD 7
`define EVD_SRC_PDAL_PAR_RD 8
`define EVD_SRC_MEM_UNCORR_RD 9
`define EVD_SRC_MEM_CORR 10
`define EVD_SRC_MEM_NONEXIST_RD 11
`define EVD_SRC_MEM_WR_ERR 12
`define EVD_SRC_IOB_PAR_RD 13
`define EVD_SRC_IOB_NONEXIST_TMO 14
`define EVD_SRC_XB_RD_ERR 15
`define EVD_SRC_XB_WR_ERR 16
`define EVD_SRC_WIDTH 17

`endif

// File: pkg/evd_pkg.sv
/*
  types shared by the error vector dispatch design files.
  assumes evd_regs.svh sits on the include path.
*/
package evd_pkg;
  `include "evd_regs.svh"

  // ============================================================
  // error categories; dispatch priority comes from pick, which ranks kernel stack invalid above machine check
  typedef enum logic [2:0] {
    EVD_CAT_NONE,
    EVD_CAT_CONSOLE_HALT,
    EVD_CAT_MACHINE_CHECK,
    EVD_CAT_KSTACK_INVALID,
    EVD_CAT_POWER_FAIL,
    EVD_CAT_HARD_ERROR,
    EVD_CAT_SOFT_ERROR
  } evd_cat_t;
endpackage

// File: src/evd_classify.sv
/*
  combinational classifier: turns one cycle of error source pulses
  with their stream and access qualifiers into three category requests.
  assumes qualifiers are valid in the same cycle as the source pulses.
*/
`timescale 1ns/100ps
`include "evd_regs.svh"
module evd_classify
  import evd_pkg::*;
(
  // error sources
  input wire logic [`EVD_SRC_WIDTH-1:0] i_src,
  // qualifiers
  input wire logic i_istream,
  input wire logic i_masked_bytes,
  input wire logic i_write,
  // categories
  output logic o_mchk,
  output logic o_soft,
  output logic o_hard
);
  wire rd_d = !i_write && !i_istream;
  wire rd_i = !i_write && i_istream;

  wire mchk_sync = i_src[`EVD_SRC_FP] | i_src[`EVD_SRC_MMGT] | i_src[`EVD_SRC_UCODE];
  wire mchk_pc = rd_d & (i_src[`EVD_SRC_PC_TAG_RD] | i_src[`EVD_SRC_PC_DATA_RD]);
  wire soft_pc = (rd_i & (i_src[`EVD_SRC_PC_TAG_RD] | i_src[`EVD_SRC_PC_DATA_RD]))
                 | i_src[`EVD_SRC_PC_TAG_WR];
  wire mchk_bc = !i_write & i_src[`EVD_SRC_BC_DATA_RD];
  wire soft_bc = !i_write & i_src[`EVD_SRC_BC_TAG_RD];
  wire mchk_pdal = rd_d & !i_masked_bytes & i_src[`EVD_SRC_PDAL_PAR_RD];
  wire soft_pdal = !i_write & (i_masked_bytes | i_istream) & i_src[`EVD_SRC_PDAL_PAR_RD];
  wire mchk_mem = (rd_d & i_src[`EVD_SRC_MEM_UNCORR_RD])
                  | (!i_write & i_src[`EVD_SRC_MEM_NONEXIST_RD]);
  wire soft_mem = (rd_i & i_src[`EVD_SRC_MEM_UNCORR_RD]) | i_src[`EVD_SRC_MEM_CORR];
  wire hard_mem = i_src[`EVD_SRC_MEM_WR_ERR];
  wire mchk_iob = (!i_write & i_src[`EVD_SRC_IOB_PAR_RD])
                  | (rd_d & i_src[`EVD_SRC_IOB_NONEXIST_TMO]);
  wire soft_iob = rd_i & i_src[`EVD_SRC_IOB_NONEXIST_TMO];
  wire hard_iob = i_write & i_src[`EVD_SRC_IOB_NONEXIST_TMO];
  wire mchk_xb = i_src[`EVD_SRC_XB_RD_ERR];
  wire hard_xb = i_src[`EVD_SRC_XB_WR_ERR];

  assign o_mchk = mchk_sync | mchk_pc | mchk_bc | mchk_pdal | mchk_mem | mchk_iob | mchk_xb;
  assign o_soft = soft_pc | soft_bc | soft_pdal | soft_mem | soft_iob;
  assign o_hard = hard_mem | hard_iob | hard_xb;
endmodule

// File: src/evd_dispatch.sv
/*
  error vector dispatch: latches classified error requests, picks the most
  severe pending one, and either halts to console firmware or fetches the
  handler address from the system control block and hands it to the core.
  assumes a core that acknowledges each dispatch with a one-cycle pulse and
  a memory read port that answers each request with one valid pulse.
*/
// Function
// - synchronous execution errors go to machine check
// - power loss raises power-fail at index 0C
// - asynchronous lossy errors raise hard error
// - non-fatal errors raise soft error at 54
// - stack push fault dispatches kernel stack invalid
// - listed fatal conditions halt to console directly
// - primary cache data-stream read parity: machine check
// - primary cache instruction-stream read parity: soft error
// - primary cache write tag parity: soft error
// - backup data parity check; backup tag soft
// - line parity: unmasked check, masked/instruction soft
// - uncorrectable memory: data check, instruction soft
// - correctable memory errors only soft error
// - nonexistent memory on read: machine check
// - memory write errors raise hard error
// - I/O bus read parity: machine check
// - I/O bus timeout: check, soft, hard
// - expansion bus reads check, writes hard
// - machine check leaves instruction retry possible
// - DMA errors use the device's own interrupt
`timescale 1ns/100ps
`include "evd_regs.svh"
module evd_dispatch
  import evd_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int POWER_FAIL_CYCLES = (`EVD_POWER_FAIL_MS * 1000000) / `EVD_CLK_PERIOD_NS
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // error detectors
  input wire logic [`EVD_SRC_WIDTH-1:0] i_err_src,
  input wire logic i_err_istream,
  input wire logic i_err_masked_bytes,
  input wire logic i_err_write,
  input wire logic i_power_good,
  input wire logic i_kstack_push_fault,
  input wire logic i_halt_cond,
  // control block base and table read port
  input wire logic [ADDR_W-1:0] i_system_control_block_base,
  input wire logic i_rd_valid,
  input wire logic [ADDR_W-1:0] i_rd_data,
  output logic o_rd_req,
  output logic [ADDR_W-1:0] o_rd_addr,
  // core handoff
  input wire logic i_core_ack,
  output logic o_dispatch,
  output logic [ADDR_W-1:0] o_handler,
  output logic [8:0] o_index,
  output logic o_console_halt,
  output logic o_hold_retry,
  output logic o_power_window
);
  typedef enum logic [1:0] {EVD_ST_IDLE, EVD_ST_FETCH, EVD_ST_WAIT, EVD_ST_HAND} evd_st_t;

  // ============================================================
  // classification
  logic cls_mchk;
  logic cls_soft;
  logic cls_hard;

  evd_classify u_classify (
    .i_src(i_err_src),
    .i_istream(i_err_istream),
    .i_masked_bytes(i_err_masked_bytes),
    .i_write(i_err_write),
    .o_mchk(cls_mchk),
    .o_soft(cls_soft),
    .o_hard(cls_hard)
  );

  function automatic logic [8:0] evd_index(input evd_cat_t c);
    case (c)
      EVD_CAT_MACHINE_CHECK: evd_index = `EVD_IDX_MACHINE_CHECK;
      EVD_CAT_KSTACK_INVALID: evd_index = `EVD_IDX_KSTACK_INVALID;
      EVD_CAT_POWER_FAIL: evd_index = `EVD_IDX_POWER_FAIL;
      EVD_CAT_HARD_ERROR: evd_index = `EVD_IDX_HARD_ERROR;
      EVD_CAT_SOFT_ERROR: evd_index = `EVD_IDX_SOFT_ERROR;
      default: evd_index = 9'h000;
    endcase
  endfunction

  // ============================================================
  // pending requests; a new event wins over the clear in the same cycle
  logic mchk_q, soft_q, hard_q, ksnv_q, pwr_q, halt_q, pg_q;
  evd_st_t st_q;
  evd_cat_t cat_q;

  wire pwr_drop = pg_q && !i_power_good;
  wire busy = st_q != EVD_ST_IDLE;
  wire start = !busy && !halt_q;
  // double error: a machine check seen while one is already in service
  wire dbl_err = cls_mchk && busy && cat_q == EVD_CAT_MACHINE_CHECK;

  evd_cat_t pick;
  assign pick = ksnv_q ? EVD_CAT_KSTACK_INVALID :
                mchk_q ? EVD_CAT_MACHINE_CHECK :
                pwr_q ? EVD_CAT_POWER_FAIL :
                hard_q ? EVD_CAT_HARD_ERROR :
                soft_q ? EVD_CAT_SOFT_ERROR : EVD_CAT_NONE;
  wire take = start && pick != EVD_CAT_NONE;
  wire taken_mchk = take && pick == EVD_CAT_MACHINE_CHECK;
  wire taken_soft = take && pick == EVD_CAT_SOFT_ERROR;
  wire taken_hard = take && pick == EVD_CAT_HARD_ERROR;
  wire taken_ksnv = take && pick == EVD_CAT_KSTACK_INVALID;
  wire taken_pwr = take && pick == EVD_CAT_POWER_FAIL;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mchk_q <= 1'b0;
      soft_q <= 1'b0;
      hard_q <= 1'b0;
      ksnv_q <= 1'b0;
      pwr_q <= 1'b0;
      halt_q <= 1'b0;
      pg_q <= 1'b1;
    end else begin
      mchk_q <= cls_mchk | (mchk_q & !taken_mchk);
      soft_q <= cls_soft | (soft_q & !taken_soft);
      hard_q <= cls_hard | (hard_q & !taken_hard);
      ksnv_q <= i_kstack_push_fault | (ksnv_q & !taken_ksnv);
      pwr_q <= pwr_drop | (pwr_q & !taken_pwr);
      halt_q <= halt_q | i_halt_cond | dbl_err;
      pg_q <= i_power_good;
    end
  end

  // ============================================================
  // dispatch sequence
  evd_st_t st_d;
  wire [ADDR_W-1:0] entry_addr = i_system_control_block_base + ADDR_W'(evd_index(pick));

  always_comb begin
    st_d = st_q;
    case (st_q)
      EVD_ST_IDLE: if (take) st_d = EVD_ST_FETCH;
      EVD_ST_FETCH: st_d = EVD_ST_WAIT;
      EVD_ST_WAIT: if (i_rd_valid) st_d = EVD_ST_HAND;
      EVD_ST_HAND: if (i_core_ack) st_d = EVD_ST_IDLE;
      default: st_d = EVD_ST_IDLE;
    endcase
  end

  logic rd_req_q, dispatch_q, halt_out_q, retry_q;
  logic [ADDR_W-1:0] rd_addr_q, handler_q;
  logic [8:0] index_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= EVD_ST_IDLE;
      cat_q <= EVD_CAT_NONE;
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
      handler_q <= '0;
      index_q <= 9'h000;
      dispatch_q <= 1'b0;
      halt_out_q <= 1'b0;
      retry_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_req_q <= take;
      halt_out_q <= halt_q;
      if (take) begin
        cat_q <= pick;
        rd_addr_q <= entry_addr;
        index_q <= evd_index(pick);
        retry_q <= pick == EVD_CAT_MACHINE_CHECK;
      end else if (st_q == EVD_ST_HAND && i_core_ack) begin
        cat_q <= EVD_CAT_NONE;
        retry_q <= 1'b0;
      end
      if (st_q == EVD_ST_WAIT && i_rd_valid) begin
        handler_q <= i_rd_data;
        dispatch_q <= 1'b1;
      end else if (i_core_ack) begin
        dispatch_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // power-fail save window count; a full 20 ms count is long for simulation
  logic [31:0] pw_cnt_q;
  logic pw_win_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pw_cnt_q <= 32'h0;
      pw_win_q <= 1'b0;
    end else if (pwr_drop) begin
      pw_cnt_q <= 32'(POWER_FAIL_CYCLES);
      pw_win_q <= 1'b1;
    end else if (pw_cnt_q != 32'h0) begin
      pw_cnt_q <= pw_cnt_q - 32'h1;
      pw_win_q <= pw_cnt_q != 32'h1;
    end
  end

  // DMA errors travel on the device's own interrupt, never through here
  assign o_rd_req = rd_req_q;
  assign o_rd_addr = rd_addr_q;
  assign o_dispatch = dispatch_q;
  assign o_handler = handler_q;
  assign o_index = index_q;
  assign o_console_halt = halt_out_q;
  assign o_hold_retry = retry_q;
  assign o_power_window = pw_win_q;

  // ============================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_mchk_index_sel: assert property (take && pick == EVD_CAT_MACHINE_CHECK |=> o_index == 9'h004 && o_rd_req)
    else $error("machine check index wrong");
  a_pwr_fail_pend: assert property (pg_q && !i_power_good |=> pwr_q)
    else $error("power drop not latched");
  a_hard_on_write: assert property (i_err_src[`EVD_SRC_MEM_WR_ERR] |=> hard_q)
    else $error("memory write error not hard");
  a_soft_corr_only: assert property (
    i_err_src == (1 << `EVD_SRC_MEM_CORR) |-> cls_soft && !cls_mchk && !cls_hard)
    else $error("correctable error misrouted");
  a_ksnv_first: assert property (take && ksnv_q |=> o_index == `EVD_IDX_KSTACK_INVALID && o_rd_req)
    else $error("kernel stack invalid not first");
  a_halt_sticks: assert property (halt_q |=> o_console_halt && !o_rd_req)
    else $error("console halt not held");
  a_pc_istream_soft: assert property (i_err_src == (1 << `EVD_SRC_PC_TAG_RD) && !i_err_write && i_err_istream
    |-> cls_soft && !cls_mchk)
    else $error("instruction tag parity misrouted");
  a_fetch_addr: assert property (
    o_rd_req |-> o_rd_addr == $past(i_system_control_block_base) + ADDR_W'(o_index))
    else $error("entry fetch address wrong");
  a_retry_hold: assert property (o_dispatch && cat_q == EVD_CAT_MACHINE_CHECK |-> o_hold_retry)
    else $error("retry hold missing");
  a_iob_write_hard: assert property (
    i_err_src == (1 << `EVD_SRC_IOB_NONEXIST_TMO) && i_err_write |-> cls_hard && !cls_mchk)
    else $error("io bus write timeout misrouted");

  // classifier routing, one source at a time
  a_fp_mchk: assert property (
    i_err_src[`EVD_SRC_FP] |-> cls_mchk)
    else $error("floating point error not machine check");
  a_mmgt_mchk: assert property (
    i_err_src[`EVD_SRC_MMGT] |-> cls_mchk)
    else $error("memory management error not machine check");
  a_ucode_mchk: assert property (
    i_err_src[`EVD_SRC_UCODE] |-> cls_mchk)
    else $error("microcode error not machine check");
  a_pc_dread_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_PC_DATA_RD) && !i_err_write && !i_err_istream |-> cls_mchk && !cls_soft)
    else $error("data-stream cache parity misrouted");
  a_pc_iread_soft: assert property (
    i_err_src == (1 << `EVD_SRC_PC_DATA_RD) && !i_err_write && i_err_istream |-> cls_soft && !cls_mchk)
    else $error("instruction-stream cache parity misrouted");
  a_pc_wtag_soft: assert property (
    i_err_src == (1 << `EVD_SRC_PC_TAG_WR) |-> cls_soft && !cls_mchk && !cls_hard)
    else $error("write tag parity misrouted");
  a_bc_data_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_BC_DATA_RD) && !i_err_write |-> cls_mchk && !cls_soft)
    else $error("backup data parity misrouted");
  a_bc_tag_soft: assert property (
    i_err_src == (1 << `EVD_SRC_BC_TAG_RD) && !i_err_write |-> cls_soft && !cls_mchk)
    else $error("backup tag parity misrouted");
  a_line_unmask_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_PDAL_PAR_RD) && !i_err_write && !i_err_istream && !i_err_masked_bytes
    |-> cls_mchk && !cls_soft)
    else $error("unmasked line parity misrouted");
  a_line_mask_soft: assert property (
    i_err_src == (1 << `EVD_SRC_PDAL_PAR_RD) && !i_err_write && (i_err_masked_bytes || i_err_istream)
    |-> cls_soft && !cls_mchk)
    else $error("masked line parity misrouted");
  a_mem_uncorr_route: assert property (
    i_err_src == (1 << `EVD_SRC_MEM_UNCORR_RD) && !i_err_write
    |-> (i_err_istream ? (cls_soft && !cls_mchk) : (cls_mchk && !cls_soft)))
    else $error("uncorrectable memory error misrouted");
  a_mem_corr_write: assert property (
    i_err_src == (1 << `EVD_SRC_MEM_CORR) && i_err_write |-> cls_soft && !cls_hard)
    else $error("correctable write error misrouted");
  a_mem_nonexist_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_MEM_NONEXIST_RD) && !i_err_write |-> cls_mchk)
    else $error("nonexistent memory read not machine check");
  a_mem_wr_hard_cls: assert property (
    i_err_src == (1 << `EVD_SRC_MEM_WR_ERR) |-> cls_hard && !cls_mchk)
    else $error("memory write error not classed hard");
  a_iob_par_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_IOB_PAR_RD) && !i_err_write |-> cls_mchk)
    else $error("io bus read parity not machine check");
  a_iob_dread_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_IOB_NONEXIST_TMO) && !i_err_write && !i_err_istream |-> cls_mchk && !cls_soft)
    else $error("io bus data read timeout misrouted");
  a_xb_read_mchk: assert property (
    i_err_src == (1 << `EVD_SRC_XB_RD_ERR) |-> cls_mchk && !cls_hard)
    else $error("expansion read error misrouted");
  a_xb_write_hard: assert property (
    i_err_src == (1 << `EVD_SRC_XB_WR_ERR) |-> cls_hard && !cls_mchk)
    else $error("expansion write error misrouted");

  // entry selection and handoff
  a_hard_index: assert property (
    take && pick == EVD_CAT_HARD_ERROR |=> o_index == `EVD_IDX_HARD_ERROR && o_rd_req)
    else $error("hard error index wrong");
  a_soft_index: assert property (
    take && pick == EVD_CAT_SOFT_ERROR |=> o_index == `EVD_IDX_SOFT_ERROR && o_rd_req)
    else $error("soft error index wrong");
  a_pwr_index: assert property (
    take && pick == EVD_CAT_POWER_FAIL |=> o_index == `EVD_IDX_POWER_FAIL && o_rd_req)
    else $error("power fail index wrong");
  a_ksnv_latch: assert property (
    i_kstack_push_fault |=> ksnv_q)
    else $error("stack push fault not latched");
  a_handler_capture: assert property (
    st_q == EVD_ST_WAIT && i_rd_valid |=> o_dispatch && o_handler == $past(i_rd_data))
    else $error("handler address not captured");
  a_rd_req_pulse: assert property (
    o_rd_req |=> !o_rd_req)
    else $error("table read request longer than one cycle");
  a_retry_off_else: assert property (
    o_dispatch && cat_q != EVD_CAT_MACHINE_CHECK |-> !o_hold_retry)
    else $error("retry hold outside machine check");
  a_power_window_open: assert property (
    pwr_drop |=> o_power_window)
    else $error("power window not opened");

  // console halt
  a_halt_on_cond: assert property (
    i_halt_cond |=> halt_q)
    else $error("halt condition not latched");
  a_halt_blocks: assert property (
    halt_q |-> !take)
    else $error("dispatch taken after console halt");
  a_dbl_err_halt: assert property (
    dbl_err |-> ##2 o_console_halt)
    else $error("double error did not halt");

  c_mchk_dispatch: cover property (taken_mchk ##[1:20] o_dispatch);
  c_soft_dispatch: cover property (taken_soft ##[1:20] o_dispatch);
  c_power_fail: cover property (pwr_drop ##1 pwr_q);
  c_console_halt: cover property (dbl_err ##2 o_console_halt);
  c_hard_dispatch: cover property (taken_hard ##[1:40] o_dispatch);
endmodule

// File: sim/evd_core_model.sv
/*
  behavioural core and control-block table port facing the dispatch block.
  assumes one clock and the same synchronous active-low reset as the block.
*/
`timescale 1ns/100ps
module evd_core_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // table read port
  input wire logic i_rd_req,
  input wire logic [31:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  // dispatch handoff
  input wire logic i_dispatch,
  input wire logic [3:0] i_delay,
  output logic o_core_ack
);
  logic rd_busy_q;
  logic [3:0] rd_cnt_q;
  logic [3:0] ack_cnt_q;
  logic [31:0] addr_q;
  logic [31:0] junk_q;

  // ============================================================
  // table answers i_delay+2 cycles after the request, ack i_delay+1 cycles after dispatch rises
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_busy_q <= 1'b0;
      rd_cnt_q <= 4'h0;
      ack_cnt_q <= 4'h0;
      addr_q <= 32'h0;
      junk_q <= 32'h0;
      o_rd_valid <= 1'b0;
      o_core_ack <= 1'b0;
    end else begin
      junk_q <= junk_q + 32'h9E3779B9;
      o_rd_valid <= 1'b0;
      o_core_ack <= 1'b0;
      if (i_rd_req) begin
        rd_busy_q <= 1'b1;
        rd_cnt_q <= i_delay;
        addr_q <= i_rd_addr;
      end else if (rd_busy_q && rd_cnt_q == 4'h0) begin
        o_rd_valid <= 1'b1;
        rd_busy_q <= 1'b0;
      end else if (rd_busy_q) begin
        rd_cnt_q <= rd_cnt_q - 4'h1;
      end
      if (i_dispatch && !o_core_ack && ack_cnt_q == i_delay) begin
        o_core_ack <= 1'b1;
        ack_cnt_q <= 4'h0;
      end else if (i_dispatch && !o_core_ack) begin
        ack_cnt_q <= ack_cnt_q + 4'h1;
      end
    end
  end

  // data lines carry a moving pattern whenever no answer is valid
  assign o_rd_data = o_rd_valid ? {~addr_q[15:0], addr_q[15:0]} : junk_q;
endmodule

// File: sim/tb.sv
/*
  self-checking bench for the error vector dispatch block.
  assumes evd_pkg and evd_core_model are compiled first.
*/
`timescale 1ns/100ps
`include "evd_regs.svh"
module tb;
  localparam int PF_CYC = 16;
  localparam logic [16:0] IST_OK = 17'h04318;
  localparam logic [16:0] WR_OK = 17'h06CE0;
  localparam logic [16:0] MSK_OK = 17'h00100;
  logic i_clk_sys, i_rst_n, i_err_istream, i_err_masked_bytes, i_err_write;
  logic i_power_good, i_kstack_push_fault, i_halt_cond, i_rd_valid, i_core_ack;
  logic [16:0] i_err_src;
  logic [31:0] i_system_control_block_base, i_rd_data, o_rd_addr, o_handler, seed;
  logic o_rd_req, o_dispatch, o_console_halt, o_hold_retry, o_power_window;
  logic [8:0] o_index;
  logic [3:0] dly;
  int errors, cmp_count, pw;

  evd_dispatch #(.ADDR_W(32), .POWER_FAIL_CYCLES(PF_CYC)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_err_src(i_err_src), .i_err_istream(i_err_istream), .i_err_masked_bytes(i_err_masked_bytes),
    .i_err_write(i_err_write), .i_power_good(i_power_good), .i_kstack_push_fault(i_kstack_push_fault),
    .i_halt_cond(i_halt_cond), .i_system_control_block_base(i_system_control_block_base),
    .i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data),
    .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_core_ack(i_core_ack), .o_dispatch(o_dispatch),
    .o_handler(o_handler), .o_index(o_index), .o_console_halt(o_console_halt), .o_hold_retry(o_hold_retry),
    .o_power_window(o_power_window));
  evd_core_model core_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr),
    .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data), .i_dispatch(o_dispatch), .i_delay(dly),
    .o_core_ack(i_core_ack));

  // ============================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [8:0] exp_of(input int b, input logic ist, input logic msk, input logic wr);
    logic [8:0] mc, se, he;
    mc = `EVD_IDX_MACHINE_CHECK;
    se = `EVD_IDX_SOFT_ERROR;
    he = `EVD_IDX_HARD_ERROR;
    case (b)
      `EVD_SRC_PC_TAG_RD, `EVD_SRC_PC_DATA_RD, `EVD_SRC_MEM_UNCORR_RD: exp_of = ist ? se : mc;
      `EVD_SRC_PC_TAG_WR, `EVD_SRC_MEM_CORR: exp_of = se;
      `EVD_SRC_BC_DATA_RD, `EVD_SRC_MEM_NONEXIST_RD, `EVD_SRC_IOB_PAR_RD: exp_of = wr ? 9'h000 : mc;
      `EVD_SRC_BC_TAG_RD: exp_of = wr ? 9'h000 : se;
      `EVD_SRC_PDAL_PAR_RD: exp_of = (msk | ist) ? se : mc;
      `EVD_SRC_MEM_WR_ERR, `EVD_SRC_XB_WR_ERR: exp_of = he;
      `EVD_SRC_IOB_NONEXIST_TMO: exp_of = wr ? he : (ist ? se : mc);
      default: exp_of = mc;
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst_seq();
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    chk("reset_outs", 32'h0, 32'({o_dispatch, o_rd_req, o_console_halt, o_power_window, o_hold_retry, o_index}));
  endtask

  // q = {istream, masked, write, kstack fault, halt}
  task automatic pulse(input logic [16:0] s, input logic [4:0] q);
    @(posedge i_clk_sys);
    i_err_src <= s;
    {i_err_istream, i_err_masked_bytes, i_err_write, i_kstack_push_fault, i_halt_cond} <= q;
    @(posedge i_clk_sys);
    i_err_src <= 17'h00000;
    {i_err_istream, i_err_masked_bytes, i_err_write, i_kstack_push_fault, i_halt_cond} <= 5'h00;
  endtask

  // watches 80 cycles; checks the first dispatch, the second only when two is set, and counts the power window
  task automatic run_ev(input logic [8:0] e0, input logic [8:0] e1, input logic two);
    logic [8:0] s0, s1;
    logic [31:0] ea;
    int n;
    logic prev;
    ea = i_system_control_block_base + 32'(e0);
    s0 = 9'h000;
    s1 = 9'h000;
    n = 0;
    prev = 1'b0;
    pw = 0;
    repeat (80) begin
      @(posedge i_clk_sys);
      #1;
      if (o_power_window === 1'b1) pw++;
      if (o_dispatch === 1'b1 && prev === 1'b0) begin
        if (n == 0) begin
          s0 = o_index;
          chk("rd_addr", ea, o_rd_addr);
          chk("handler", {~ea[15:0], ea[15:0]}, o_handler);
          chk("hold_retry", 32'(e0 == `EVD_IDX_MACHINE_CHECK), 32'(o_hold_retry));
        end else if (n == 1) s1 = o_index;
        n++;
      end
      prev = o_dispatch;
    end
    chk("index", 32'(e0), 32'(s0));
    if (two) chk("index2", 32'(e1), 32'(s1));
  endtask

  // ============================================================
  // clock, watchdog, main sequence
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (15000) @(posedge i_clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    int b, n;
    logic [31:0] r;
    logic ist, msk, wr;
    logic [8:0] e;
    seed = 32'h00003053;
    errors = 0;
    cmp_count = 0;
    {i_rst_n, i_err_istream, i_err_masked_bytes, i_err_write, i_kstack_push_fault, i_halt_cond} = 6'h00;
    i_power_good = 1'b1;
    i_err_src = 17'h00000;
    i_system_control_block_base = 32'h00000000;
    dly = 4'h0;
    rst_seq();
    // every source once, then random sources, qualifiers, bases and core delays
    for (int k = 0; k < 57; k++) begin
      b = (k < 17) ? k : int'(rnd() % 17);
      r = rnd();
      ist = r[0] & IST_OK[b];
      msk = r[1] & MSK_OK[b];
      wr = r[2] & WR_OK[b];
      @(posedge i_clk_sys);
      i_system_control_block_base <= rnd();
      dly <= r[7:4];
      e = exp_of(b, ist, msk, wr);
      pulse(17'h00001 << b, {ist, msk, wr, 2'b00});
      run_ev(e, 9'h000, 1'b0);
    end
    pulse((17'h00001 << `EVD_SRC_MEM_WR_ERR) | (17'h00001 << `EVD_SRC_MEM_CORR), 5'h00);
    run_ev(`EVD_IDX_HARD_ERROR, `EVD_IDX_SOFT_ERROR, 1'b1);
    pulse(17'h00001 << `EVD_SRC_FP, 5'h02);
    run_ev(`EVD_IDX_KSTACK_INVALID, `EVD_IDX_MACHINE_CHECK, 1'b1);
    pulse(17'h00001 << `EVD_SRC_PC_TAG_WR, 5'h10);
    pulse(17'h00001 << `EVD_SRC_XB_WR_ERR, 5'h00);
    run_ev(`EVD_IDX_SOFT_ERROR, `EVD_IDX_HARD_ERROR, 1'b1);
    @(posedge i_clk_sys);
    i_power_good <= 1'b0;
    run_ev(`EVD_IDX_POWER_FAIL, 9'h000, 1'b0);
    chk("power_window", 32'(PF_CYC), 32'(pw));
    @(posedge i_clk_sys);
    i_power_good <= 1'b1;
    // second machine check while the first is still in service
    rst_seq();
    dly <= 4'hF;
    pulse(17'h00001 << `EVD_SRC_FP, 5'h00);
    n = 0;
    while (o_hold_retry !== 1'b1 && n < 20) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    pulse(17'h00001 << `EVD_SRC_UCODE, 5'h00);
    repeat (4) @(posedge i_clk_sys);
    #1;
    chk("double_halt", 32'h1, 32'(o_console_halt));
    rst_seq();
    pulse(17'h00000, 5'h01);
    pulse(17'h00001 << `EVD_SRC_MEM_CORR, 5'h00);
    run_ev(9'h000, 9'h000, 1'b0);
    chk("console_halt", 32'h1, 32'(o_console_halt));
    rst_seq();
    end_sim();
  end
endmodule
